// >>> core/bst_map.vh
// Constants for the boundary-scan test port
// Behaviour
// - The port supports EXTEST, SAMPLE/PRELOAD and BYPASS, plus the optional IDCODE instruction.
// - Opcode 00 selects EXTEST, 01 selects SAMPLE/PRELOAD and 05 selects CLAMP.
// - Opcode 0f selects IDCODE and places the identification register between TDI and TDO.
// - Opcode ff selects BYPASS and puts the one-bit bypass register in the serial path.
// - The port has five signals: test clock, data in, data out, mode select and test reset.
// - Undriven mode select, data in and test reset inputs read as logic one.
// - The controller has sixteen states in four bits, stepped by mode select at rising test clock.
// - At power-up the controller starts in Test-Logic-Reset.
// - Mode select held high for five test clock cycles brings the controller to Test-Logic-Reset.
// - Test reset forces Test-Logic-Reset at once, without a test clock edge; here it takes effect on the third core clock edge after the pin falls.
// - There are exactly three data registers, bypass, identification and boundary scan.
// - The identification register is 32 bits in four fields: low byte, ID number, part and version.
// - Each I/O has three boundary cells, each with serial in and out and parallel in and out.
// - All boundary cells form one chain from data in to data out.
// - Cell parallel ports join core logic and each pad's input, output and output enable.
// - Before the device is first programmed EXTEST is not available.
`ifndef BST_MAP_VH
`define BST_MAP_VH
`define BST_IR_W        8
`define BST_OP_EXTEST   8'h00
`define BST_OP_SAMPLE   8'h01
`define BST_OP_CLAMP    8'h05
`define BST_OP_IDCODE   8'h0f
`define BST_OP_BYPASS   8'hff
`define BST_IR_CAPTURE  8'h01
`define BST_IDCODE_RST  32'h00000001
`define BST_ID_LSB_W    8
`define BST_ID_NUM_W    8
`define BST_ID_PART_W   12
`define BST_ID_VER_W    4
`define BST_CELLS_PER_IO 3
`define BST_CELL_IN     0
`define BST_CELL_OUT    1
`define BST_CELL_OE     2
`define BST_TLR_ONES    5
`endif

// >>> core/bst_tap.v
// Boundary-scan test access port, controller, instruction and data registers
`timescale 1ns/1ps
`include "bst_map.vh"
module bst_tap #(
   parameter             NUM_IO  = 4,
   parameter [7:0]       ID_LSB  = 8'h01,   // Arbitrary identity value
   parameter [7:0]       ID_NUM  = 8'h5a,   // Arbitrary identity value
   parameter [11:0]      ID_PART = 12'h123, // Arbitrary identity value
   parameter [3:0]       ID_VER  = 4'h1     // Arbitrary identity value
) (
   input  wire              i_core_clk,
   input  wire              i_nrst,
   input  wire              i_tck,
   input  wire              i_tms,
   input  wire              i_tdi,
   input  wire              i_trst_n,
   output reg               o_tdo,
   output wire              o_tdo_oe,
   input  wire              i_programmed,
   input  wire [NUM_IO-1:0] i_core_out,
   input  wire [NUM_IO-1:0] i_core_oe,
   input  wire [NUM_IO-1:0] i_pad_in,
   output wire [NUM_IO-1:0] o_core_in,
   output wire [NUM_IO-1:0] o_pad_out,
   output wire [NUM_IO-1:0] o_pad_oe,
   output wire [3:0]        o_tap_state
);
   localparam integer BSR_W = `BST_CELLS_PER_IO * NUM_IO;
   // Sixteen states in four bits, not one-hot: the state code is a port
   localparam [3:0] S_TLR = 4'hf;
   localparam [3:0] S_RTI = 4'hc;
   localparam [3:0] S_SDR = 4'h7;
   localparam [3:0] S_CDR = 4'h6;
   localparam [3:0] S_SHD = 4'h2;
   localparam [3:0] S_E1D = 4'h1;
   localparam [3:0] S_PDR = 4'h3;
   localparam [3:0] S_E2D = 4'h0;
   localparam [3:0] S_UDR = 4'h5;
   localparam [3:0] S_SIR = 4'h4;
   localparam [3:0] S_CIR = 4'he;
   localparam [3:0] S_SHI = 4'ha;
   localparam [3:0] S_E1I = 4'h9;
   localparam [3:0] S_PIR = 4'hb;
   localparam [3:0] S_E2I = 4'h8;
   localparam [3:0] S_UIR = 4'hd;

   // ---------------------------------------------
   // Reset and pin synchronisers
   // ---------------------------------------------
   reg  [1:0] rst_sync_ff;
   wire       rst_n = rst_sync_ff[1];
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) rst_sync_ff <= 2'b00;
      else         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // Pins float high when undriven; reset values of one mirror the pull-ups
   reg  [3:0] pin_s1_ff;
   reg  [3:0] pin_s2_ff;
   reg        tck_d_ff;
   reg        trst_hold_ff;
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_ff <= 4'hf;
         pin_s2_ff <= 4'hf;
         // Matches the idle-high clock so reset gives no false edge
         tck_d_ff  <= 1'b1;
      end else begin
         pin_s1_ff <= {i_trst_n, i_tdi, i_tms, i_tck};
         pin_s2_ff <= pin_s1_ff;
         tck_d_ff  <= pin_s2_ff[0];
      end
   end
   wire tck_s  = pin_s2_ff[0];
   wire tms_s  = pin_s2_ff[1];
   wire tdi_s  = pin_s2_ff[2];
   wire trst_s = ~pin_s2_ff[3];
   wire tck_rise = tck_s & ~tck_d_ff;
   wire tck_fall = ~tck_s & tck_d_ff;
   // Test reset is a level: acts whether or not the test clock runs
   wire tap_rst = trst_s;

   // ---------------------------------------------
   // Pad input synchroniser for capture
   // ---------------------------------------------
   // Pads move at any time; only capture is delayed, the pass-through is not
   reg  [NUM_IO-1:0] pad_s1_ff;
   reg  [NUM_IO-1:0] pad_s2_ff;
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_s1_ff <= {NUM_IO{1'b0}};
         pad_s2_ff <= {NUM_IO{1'b0}};
      end else begin
         pad_s1_ff <= i_pad_in;
         pad_s2_ff <= pad_s1_ff;
      end
   end

   // ---------------------------------------------
   // Controller
   // ---------------------------------------------
   reg  [3:0] state_ff;
   reg  [3:0] nxt_state;
   always @* begin
      case (state_ff)
         S_TLR: begin
            if (tms_s) nxt_state = S_TLR;
            else       nxt_state = S_RTI;
         end
         S_RTI: begin
            if (tms_s) nxt_state = S_SDR;
            else       nxt_state = S_RTI;
         end
         S_SDR: begin
            if (tms_s) nxt_state = S_SIR;
            else       nxt_state = S_CDR;
         end
         S_CDR: begin
            if (tms_s) nxt_state = S_E1D;
            else       nxt_state = S_SHD;
         end
         S_SHD: begin
            if (tms_s) nxt_state = S_E1D;
            else       nxt_state = S_SHD;
         end
         S_E1D: begin
            if (tms_s) nxt_state = S_UDR;
            else       nxt_state = S_PDR;
         end
         S_PDR: begin
            if (tms_s) nxt_state = S_E2D;
            else       nxt_state = S_PDR;
         end
         S_E2D: begin
            if (tms_s) nxt_state = S_UDR;
            else       nxt_state = S_SHD;
         end
         S_UDR: begin
            if (tms_s) nxt_state = S_SDR;
            else       nxt_state = S_RTI;
         end
         S_SIR: begin
            if (tms_s) nxt_state = S_TLR;
            else       nxt_state = S_CIR;
         end
         S_CIR: begin
            if (tms_s) nxt_state = S_E1I;
            else       nxt_state = S_SHI;
         end
         S_SHI: begin
            if (tms_s) nxt_state = S_E1I;
            else       nxt_state = S_SHI;
         end
         S_E1I: begin
            if (tms_s) nxt_state = S_UIR;
            else       nxt_state = S_PIR;
         end
         S_PIR: begin
            if (tms_s) nxt_state = S_E2I;
            else       nxt_state = S_PIR;
         end
         S_E2I: begin
            if (tms_s) nxt_state = S_UIR;
            else       nxt_state = S_SHI;
         end
         S_UIR: begin
            if (tms_s) nxt_state = S_SDR;
            else       nxt_state = S_RTI;
         end
         default: nxt_state = S_TLR;
      endcase
   end
   // Five ones on mode select always land in Test-Logic-Reset via this graph
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n)          state_ff <= S_TLR;
      else if (tap_rst)    state_ff <= S_TLR;
      else if (tck_rise)   state_ff <= nxt_state;
   end
   assign o_tap_state = state_ff;

   // ---------------------------------------------
   // State decode
   // ---------------------------------------------
   // Decoded states keep the register logic below readable
   wire in_tlr = (state_ff == S_TLR);
   wire in_cdr = (state_ff == S_CDR);
   wire in_shd = (state_ff == S_SHD);
   wire in_udr = (state_ff == S_UDR);
   wire in_cir = (state_ff == S_CIR);
   wire in_shi = (state_ff == S_SHI);
   wire in_uir = (state_ff == S_UIR);

   // ---------------------------------------------
   // Instruction register
   // ---------------------------------------------
   reg  [`BST_IR_W-1:0] ir_sh_ff;
   reg  [`BST_IR_W-1:0] ir_ff;
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_sh_ff <= `BST_OP_IDCODE;
      end else if (tck_rise) begin
         if (in_cir) begin
            ir_sh_ff <= `BST_IR_CAPTURE;
         end else if (in_shi) begin
            ir_sh_ff <= {tdi_s, ir_sh_ff[`BST_IR_W-1:1]};
         end
      end
   end

   // Test reset wins over an update in the same cycle
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_ff <= `BST_OP_IDCODE;
      end else if (tap_rst) begin
         ir_ff <= `BST_OP_IDCODE;
      end else if (tck_rise) begin
         if (in_tlr) begin
            ir_ff <= `BST_OP_IDCODE;
         end else if (in_uir) begin
            ir_ff <= ir_sh_ff;
         end
      end
   end

   // ---------------------------------------------
   // Instruction decode
   // ---------------------------------------------
   // Unprogrammed part falls back to bypass on EXTEST
   wire op_extest = (ir_ff == `BST_OP_EXTEST) & i_programmed;
   wire op_sample = (ir_ff == `BST_OP_SAMPLE);
   wire op_clamp  = (ir_ff == `BST_OP_CLAMP);
   wire op_idcode = (ir_ff == `BST_OP_IDCODE);
   // Any unknown opcode also picks bypass, as the standard wants
   wire sel_bsr   = op_extest | op_sample;
   wire sel_id    = op_idcode;

   // ---------------------------------------------
   // Data registers
   // ---------------------------------------------
   reg              byp_ff;
   reg  [31:0]      id_ff;
   reg  [BSR_W-1:0] bsr_sh_ff;
   reg  [BSR_W-1:0] bsr_up_ff;
   wire [BSR_W-1:0] bsr_pin;
   // Three cells per pad: pad input, core output, output enable
   genvar g;
   generate
      for (g = 0; g < NUM_IO; g = g + 1) begin : g_io
         assign bsr_pin[3*g+`BST_CELL_IN]  = pad_s2_ff[g];
         assign bsr_pin[3*g+`BST_CELL_OUT] = i_core_out[g];
         assign bsr_pin[3*g+`BST_CELL_OE]  = i_core_oe[g];
         assign o_core_in[g] = op_extest ? bsr_up_ff[3*g+`BST_CELL_IN] : i_pad_in[g];
         assign o_pad_out[g] = (op_extest | op_clamp) ?
                               bsr_up_ff[3*g+`BST_CELL_OUT] : i_core_out[g];
         assign o_pad_oe[g]  = (op_extest | op_clamp) ?
                               bsr_up_ff[3*g+`BST_CELL_OE] : i_core_oe[g];
      end
   endgenerate

   // ---------------------------------------------
   // Bypass register
   // ---------------------------------------------
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         byp_ff <= 1'b0;
      end else if (tck_rise) begin
         if (in_cdr) begin
            byp_ff <= 1'b0;
         end else if (in_shd && !sel_bsr && !sel_id) begin
            byp_ff <= tdi_s;
         end
      end
   end

   // ---------------------------------------------
   // Identification register
   // ---------------------------------------------
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         id_ff <= `BST_IDCODE_RST;
      end else if (tck_rise) begin
         if (in_cdr) begin
            id_ff <= {ID_VER, ID_PART, ID_NUM, ID_LSB};
         end else if (in_shd && sel_id) begin
            id_ff <= {tdi_s, id_ff[31:1]};
         end
      end
   end

   // ---------------------------------------------
   // Boundary register
   // ---------------------------------------------
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bsr_sh_ff <= {BSR_W{1'b0}};
      end else if (tck_rise) begin
         if (in_cdr && sel_bsr) begin
            bsr_sh_ff <= bsr_pin;
         end else if (in_shd && sel_bsr) begin
            bsr_sh_ff <= {tdi_s, bsr_sh_ff[BSR_W-1:1]};
         end
      end
   end

   // Update stage holds pad values steady while the chain shifts
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bsr_up_ff <= {BSR_W{1'b0}};
      end else if (tck_rise) begin
         if (in_udr && sel_bsr) begin
            bsr_up_ff <= bsr_sh_ff;
         end
      end
   end

   // ---------------------------------------------
   // Serial output
   // ---------------------------------------------
   reg  tdo_oe_ff;
   wire dr_bit = sel_bsr ? bsr_sh_ff[0] : (sel_id ? id_ff[0] : byp_ff);
   always @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_tdo     <= 1'b0;
         tdo_oe_ff <= 1'b0;
      end else if (tap_rst) begin
         tdo_oe_ff <= 1'b0;
      end else if (tck_fall) begin
         // Updated half a test clock after the shift edge, LSB first
         if (in_shi) begin
            o_tdo <= ir_sh_ff[0];
         end else begin
            o_tdo <= dr_bit;
         end
         tdo_oe_ff <= in_shi | in_shd;
      end
   end
   assign o_tdo_oe = tdo_oe_ff;
endmodule // bst_tap

// >>> testbench/bst_jtag_host.sv
// External test controller model driving the test port
`timescale 1ns/1ps
module bst_jtag_host (
   input  wire i_clk,
   input  wire i_tdo,
   output reg  o_tck,
   output reg  o_tms,
   output reg  o_tdi,
   output reg  o_trst_n
);
   initial {o_tck, o_tms, o_tdi, o_trst_n} = 4'hf;
   // One test clock period; clock stands high between calls
   task step(input bit tms, input bit tdi, output logic tdo);
      @(negedge i_clk) o_tck <= 1'b0;
      o_tms <= tms;
      o_tdi <= tdi;
      repeat (4) @(negedge i_clk);
      tdo = i_tdo;
      o_tck <= 1'b1;
      repeat (4) @(negedge i_clk);
   endtask
endmodule // bst_jtag_host

// >>> testbench/bst_tap_props.sv
// Assertions on the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_props (
   input wire       i_core_clk,
   input wire       i_nrst,
   input wire       i_tck,
   input wire       i_tms,
   input wire       i_trst_n,
   input wire       o_tdo,
   input wire       o_tdo_oe,
   input wire [3:0] o_tap_state
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);
   reg       tck_ff;
   reg [2:0] ones_ff;
   // Counts test clock rises with mode select high, saturating at five
   always @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tck_ff  <= 1'b0;
         ones_ff <= 3'h0;
      end else begin
         tck_ff <= i_tck;
         if (i_tck && !tck_ff)
            ones_ff <= !i_tms ? 3'h0 : (ones_ff == 3'h5) ? 3'h5 : ones_ff + 3'h1;
      end
   end
   chk_power_state: assert property ($rose(i_nrst) |-> o_tap_state == 4'hf)
      else $error("state not reset at power-up");
   chk_tdo_float: assert property ($rose(o_tdo_oe) |-> o_tap_state inside {4'h2, 4'ha})
      else $error("data out driven outside shift");
   chk_ir_capture: assert property ($rose(o_tdo_oe) && o_tap_state == 4'ha |-> o_tdo)
      else $error("first instruction bit not one");
   chk_tdo_fall: assert property (o_tdo_oe && $changed(o_tdo) |-> !$past(i_tck))
      else $error("data out moved while test clock high");
   chk_trst_reset: assert property ($fell(i_trst_n) |-> ##[1:4] o_tap_state == 4'hf)
      else $error("test reset too slow");
   chk_trst_hold: assert property (!i_trst_n [*5] |-> o_tap_state == 4'hf && !o_tdo_oe)
      else $error("test reset not held");
   chk_tms_five: assert property ($rose(ones_ff == 3'h5) |-> ##[1:6] o_tap_state == 4'hf)
      else $error("five ones did not reset");
   chk_tlr_step: assert property (o_tap_state == 4'hf && $rose(i_tck) && !i_tms
      |-> ##[1:5] o_tap_state == 4'hc)
      else $error("no step to idle");
   cover property ($rose(ones_ff == 3'h5));
   cover property ($rose(o_tdo_oe) && o_tap_state == 4'h2);
   cover property ($fell(i_trst_n));
endmodule // bst_tap_props
bind bst_tap bst_tap_props bst_tap_props_i (.*);

// >>> testbench/bst_tap_tb.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module bst_tap_tb;
   logic       clk = 1'b0, nrst = 1'b0, prog = 1'b1;
   logic [3:0] cout = 4'h5, coe = 4'h3, pin = 4'ha;
   wire        tck, tms, tdi, trst_n, tdo, oe, tdo_w;
   wire  [3:0] cin, pout, poe, st;
   int         err_count = 0, check_count = 0;
   assign tdo_w = oe ? tdo : 1'b1; // Pull-up holds the released line high
   always #2 clk = ~clk;
   bst_jtag_host bst_jtag_host_i (.i_clk(clk), .i_tdo(tdo_w), .o_tck(tck), .o_tms(tms),
      .o_tdi(tdi), .o_trst_n(trst_n));
   bst_tap bst_tap_i (.i_core_clk(clk), .i_nrst(nrst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(oe), .i_programmed(prog), .i_core_out(cout),
      .i_core_oe(coe), .i_pad_in(pin), .o_core_in(cin), .o_pad_out(pout), .o_pad_oe(poe),
      .o_tap_state(st));
   task chk(string what, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task tick(bit m, bit d);
      logic x;
      bst_jtag_host_i.step(m, d, x);
   endtask
   // From idle through one shift of n bits and back to idle
   task scan(bit ir, int n, logic [31:0] din, output logic [31:0] dout);
      logic x;
      tick(1, 0);
      if (ir) tick(1, 0);
      tick(0, 0);
      tick(0, 0);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         bst_jtag_host_i.step(i == n - 1, din[i], x);
         dout[i] = x;
      end
      tick(1, 0);
      tick(0, 0);
   endtask
   task load_ir(logic [7:0] op);
      logic [31:0] c;
      scan(1, 8, {24'h0, op}, c);
      chk("ir capture", 32'h1, c);
   endtask
   task t_bypass(logic [7:0] op);
      logic [31:0] q;
      load_ir(op);
      scan(0, 8, 32'hb5, q);
      chk("bypass path", 32'h6a, q);
      chk("pads", {cout, coe}, {pout, poe});
      $display("bypass test done");
   endtask
   task t_extest(logic [7:0] op);
      logic [31:0] q;
      load_ir(8'h01);
      scan(0, 12, 32'hc96, q);
      load_ir(op);
      chk("pad drive", 8'hf9, {pout, poe});
      $display("drive test done");
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      err_count++;
      complete_run;
   end
   initial begin
      logic [31:0] q, e;
      repeat (16) @(negedge clk);
      nrst <= 1'b1;
      repeat (6) @(negedge clk);
      chk("power state", 4'hf, st);
      tick(0, 0);
      load_ir(8'h0f);
      scan(0, 32, 32'h0, q);
      chk("idcode", 32'h1123_5a01, q);
      t_bypass(8'hff);
      prog <= 1'b0;
      t_bypass(8'h00);
      prog <= 1'b1;
      load_ir(8'h01);
      scan(0, 12, 32'h0, q);
      e = '0;
      for (int i = 0; i < 4; i++) e[3*i +: 3] = {coe[i], cout[i], pin[i]};
      chk("sample cells", e, q);
      chk("pass through", {pin, cout, coe}, {cin, pout, poe});
      t_extest(8'h00);
      t_extest(8'h05);
      tick(1, 0);
      tick(0, 0);
      tick(0, 0);
      repeat (5) tick(1, 0);
      chk("five ones", 4'hf, st);
      tick(1, 0);
      tick(0, 0);
      tick(1, 0);
      tick(0, 0);
      tick(0, 0);
      chk("shift state", 4'h2, st);
      bst_jtag_host_i.o_trst_n <= 1'b0;
      repeat (8) @(negedge clk);
      chk("test reset", 5'h1e, {st, oe});
      bst_jtag_host_i.o_trst_n <= 1'b1;
      repeat (4) @(negedge clk);
      tick(0, 0);
      chk("idle", 4'hc, st);
      $display("control test done");
      complete_run;
   end
endmodule // bst_tap_tb
